// File: src/mfs_pkg.sv
package mfs_pkg;
  localparam int STRIPS = 32;
  localparam logic [6:0] NOTE_MUTE_BASE = 7'h00;
  localparam logic [6:0] NOTE_SEL_BASE = 7'h20;
  localparam logic [6:0] NOTE_LISTEN_BASE = 7'h40;
  localparam logic [6:0] NOTE_LAST = 7'h5f;
  localparam logic [3:0] STAT_NOTE_OFF = 4'h8;
  localparam logic [3:0] STAT_NOTE_ON = 4'h9;
  localparam logic [3:0] STAT_CC = 4'hb;
  localparam logic [3:0] STAT_PROG = 4'hc;
  localparam logic [6:0] VEL_ON = 7'h7f;
  localparam logic [3:0] MAIN_CH_RESET = 4'h0;
  localparam logic [3:0] CH_LAST = 4'hf;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PEND = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_MUTE = 8'h0c;
  localparam logic [7:0] ADDR_SEL = 8'h10;
  localparam logic [7:0] ADDR_LISTEN = 8'h14;
  localparam logic [7:0] ADDR_FADER = 8'h18;
  // pending settings field layout
  localparam int PEND_CH_LSB = 0;
  localparam int PEND_LAW_BIT = 4;
  // control bits
  localparam int CTRL_APPLY_BIT = 0;
  localparam int CTRL_CANCEL_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // mmc
  localparam logic [7:0] SYSEX_START = 8'hf0;
  localparam logic [7:0] SYSEX_END = 8'hf7;
  localparam logic [7:0] MMC_ALL = 8'h7f;
  localparam logic [7:0] MMC_ID_RT = 8'h7f;
  localparam logic [7:0] MMC_SUB_CMD = 8'h06;

  typedef enum logic {
    MFS_LAW_LINEAR = 1'b0,
    MFS_LAW_AUDIO = 1'b1
  } mfs_law_t;

  typedef enum logic [2:0] {
    MFS_SOFT_NOTE = 3'h0,
    MFS_SOFT_CC_ABS = 3'h1,
    MFS_SOFT_CC_REL = 3'h2,
    MFS_SOFT_MMC = 3'h3,
    MFS_SOFT_PROG = 3'h4
  } mfs_soft_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] data1;
    logic [7:0] data2;
  } mfs_msg_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [4:0] strip;
  } mfs_key_t;

  localparam logic [1:0] KEY_MUTE = 2'h0;
  localparam logic [1:0] KEY_SEL = 2'h1;
  localparam logic [1:0] KEY_LISTEN = 2'h2;
endpackage : mfs_pkg

// File: src/mfs_law.sv
`timescale 1ns/1ps
module mfs_law (
  input wire logic law,
  input wire logic [9:0] pos_in,
  input wire logic [6:0] val_in,
  output logic [6:0] val_out,
  output logic [9:0] pos_out
);
  // audio taper: shallow over the lower half, steeper in each upper quarter
  wire [6:0] lin_fwd = pos_in[9:3];
  wire [6:0] aud_fwd = !pos_in[9] ? {2'h0, pos_in[8:4]} :
                       !pos_in[8] ? {2'h1, pos_in[7:3]} :
                       {1'b1, pos_in[7:2]};
  wire [9:0] lin_inv = {val_in, 3'h0};
  wire [9:0] aud_inv = (val_in[6:5] == 2'h0) ?
                       {1'b0, val_in[4:0], 4'h0} :
                       !val_in[6] ? {2'h2, val_in[4:0], 3'h0} :
                       {2'h3, val_in[5:0], 2'h0};
  assign val_out = law ? aud_fwd : lin_fwd;
  assign pos_out = law ? aud_inv : lin_inv;
endmodule : mfs_law

// File: src/mfs_tx.sv
`timescale 1ns/1ps
module mfs_tx (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire mfs_pkg::mfs_msg_t msg,
  input wire logic [2:0] len,
  output logic busy,
  output logic [7:0] byte_data,
  output logic byte_valid,
  input wire logic byte_ready
);
  logic [23:0] sh_q;
  logic [2:0] cnt_q;
  assign busy = cnt_q != 3'h0;
  assign byte_valid = busy;
  assign byte_data = sh_q[23:16];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 24'h0;
      cnt_q <= 3'h0;
    end else if (load && !busy) begin
      sh_q <= msg;
      cnt_q <= len;
    end else if (busy && byte_ready) begin
      sh_q <= {sh_q[15:0], 8'h0};
      cnt_q <= cnt_q - 3'h1;
    end
  end
endmodule : mfs_tx

// File: src/mfs_strip_mapper.sv
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
// Function
// - thirty-two strips each with mute, select, listen keys and a fader.
// - key press sends note on then matching note off.
// - fader n movement sends controller n.
// - mute keys map to notes 0 to 31.
// - select keys map to notes 32 to 63.
// - listen keys map to notes 64 to 95.
// - received notes and controllers update key state or fader.
// - strip messages go to both usb and network links.
// - default strip channel is channel 2.
// - strip channel is main plus one, wrapping 16 to 1.
// - transport button sends machine control message to all channels.
// - fader law selectable linear or audio, both directions.
// - channel and law changes take effect on apply, dropped on cancel.
// - soft controls send note, cc abs, cc rel, program change; the mmc kind sends a cc.
module mfs_strip_mapper #(
  parameter int STRIPS = mfs_pkg::STRIPS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic key_press,
  input wire mfs_pkg::mfs_key_t key_id,
  input wire logic fader_move,
  input wire logic [4:0] fader_id,
  input wire logic [9:0] fader_pos,
  input wire logic mmc_go,
  input wire logic [7:0] mmc_cmd,
  input wire logic soft_go,
  input wire mfs_pkg::mfs_soft_t soft_kind,
  input wire logic [6:0] soft_num,
  input wire logic [6:0] soft_val,
  output logic cmd_ready,
  input wire logic rx_valid,
  input wire mfs_pkg::mfs_msg_t rx_msg,
  output logic [7:0] usb_data,
  output logic usb_valid,
  input wire logic usb_ready,
  output logic [7:0] net_data,
  output logic net_valid,
  input wire logic net_ready,
  output logic [STRIPS-1:0] mute_state,
  output logic [STRIPS-1:0] sel_state,
  output logic [STRIPS-1:0] listen_state,
  output logic fader_upd,
  output logic [4:0] fader_upd_id,
  output logic [9:0] fader_upd_pos
);
  // ****************************************
  // settings
  // ****************************************
  logic [3:0] main_ch_q, pend_ch_q;
  logic law_q, pend_law_q;
  logic [STRIPS-1:0] mute_q, sel_q, listen_q;
  logic [6:0] last_cc_q;
  wire [3:0] strip_ch = (main_ch_q == mfs_pkg::CH_LAST) ? 4'h0 :
                        main_ch_q + 4'h1;

  function automatic logic [6:0] key_note(input mfs_pkg::mfs_key_t k);
    unique case (k.kind)
      mfs_pkg::KEY_SEL: key_note = mfs_pkg::NOTE_SEL_BASE + {2'h0, k.strip};
      mfs_pkg::KEY_LISTEN: key_note = mfs_pkg::NOTE_LISTEN_BASE +
                                       {2'h0, k.strip};
      default: key_note = mfs_pkg::NOTE_MUTE_BASE + {2'h0, k.strip};
    endcase
  endfunction : key_note

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic aw_q, w_q, bv_q, rv_q, apply_p, cancel_p;
  logic [7:0] awa_q;
  logic [31:0] wd_q, rd_q;
  logic [1:0] br_q, rr_q;
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;
  wire wr_go = aw_q && w_q && !bv_q;
  wire wr_ctrl = wr_go && awa_q == mfs_pkg::ADDR_CTRL && wd_q[0 +: 8] != 8'h0;
  wire wr_pend = wr_go && awa_q == mfs_pkg::ADDR_PEND;
  wire wr_ok = awa_q == mfs_pkg::ADDR_CTRL || awa_q == mfs_pkg::ADDR_PEND;
  assign apply_p = wr_ctrl && wd_q[mfs_pkg::CTRL_APPLY_BIT];
  assign cancel_p = wr_ctrl && !wd_q[mfs_pkg::CTRL_APPLY_BIT] &&
                    wd_q[mfs_pkg::CTRL_CANCEL_BIT];
  logic [31:0] rmux;
  logic rhit;
  always_comb begin
    rhit = 1'b1;
    unique case (s_axi_araddr)
      mfs_pkg::ADDR_CTRL: rmux = 32'h0;
      mfs_pkg::ADDR_PEND: rmux = {27'h0, pend_law_q, pend_ch_q};
      mfs_pkg::ADDR_STAT: rmux = {19'h0, last_cc_q, law_q, main_ch_q, 1'b0};
      mfs_pkg::ADDR_MUTE: rmux = 32'(mute_q);
      mfs_pkg::ADDR_SEL: rmux = 32'(sel_q);
      mfs_pkg::ADDR_LISTEN: rmux = 32'(listen_q);
      mfs_pkg::ADDR_FADER: rmux = {25'h0, last_cc_q};
      default: begin
        rmux = 32'h0;
        rhit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      awa_q <= 8'h0;
      wd_q <= 32'h0;
      rd_q <= 32'h0;
      br_q <= mfs_pkg::RESP_OKAY;
      rr_q <= mfs_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bv_q <= 1'b1;
        br_q <= wr_ok ? mfs_pkg::RESP_OKAY : mfs_pkg::RESP_SLVERR;
      end else if (bv_q && s_axi_bready) begin
        bv_q <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rv_q <= 1'b1;
        rd_q <= rmux;
        rr_q <= rhit ? mfs_pkg::RESP_OKAY : mfs_pkg::RESP_SLVERR;
      end else if (rv_q && s_axi_rready) begin
        rv_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // settings registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // default main 1 gives strip channel 2
      main_ch_q <= mfs_pkg::MAIN_CH_RESET;
      pend_ch_q <= mfs_pkg::MAIN_CH_RESET;
      law_q <= mfs_pkg::MFS_LAW_LINEAR;
      pend_law_q <= mfs_pkg::MFS_LAW_LINEAR;
    end else if (wr_pend && s_axi_wstrb != 4'h0) begin
      pend_ch_q <= wd_q[mfs_pkg::PEND_CH_LSB +: 4];
      pend_law_q <= wd_q[mfs_pkg::PEND_LAW_BIT];
    end else if (apply_p) begin
      main_ch_q <= pend_ch_q;
      law_q <= pend_law_q;
    end else if (cancel_p) begin
      pend_ch_q <= main_ch_q;
      pend_law_q <= law_q;
    end
  end

  // ****************************************
  // transmit path
  // ****************************************
  logic [6:0] cc_val;
  logic [9:0] rx_pos;
  mfs_law u_law (
    .law(law_q),
    .pos_in(fader_pos),
    .val_in(rx_msg.data2[6:0]),
    .val_out(cc_val),
    .pos_out(rx_pos)
  );
  logic off_pend_q;
  logic [6:0] off_note_q;
  mfs_pkg::mfs_msg_t tmsg;
  logic [2:0] tlen;
  logic tload;
  logic [1:0] mmc_step_q;
  logic [7:0] mmc_cmd_q;
  logic usb_busy, net_busy;
  wire idle = !usb_busy && !net_busy;
  assign cmd_ready = idle && !off_pend_q && mmc_step_q == 2'h0;
  always_comb begin
    tload = idle;
    tlen = 3'h3;
    tmsg = '0;
    if (off_pend_q) begin
      tmsg = {mfs_pkg::STAT_NOTE_OFF, strip_ch, 1'b0, off_note_q, 8'h0};
    end else if (mmc_step_q != 2'h0) begin
      unique case (mmc_step_q)
        2'h1: tmsg = {mfs_pkg::MMC_SUB_CMD, mmc_cmd_q, mfs_pkg::SYSEX_END};
        default: tmsg = '0;
      endcase
    end else if (key_press) begin
      tmsg = {mfs_pkg::STAT_NOTE_ON, strip_ch, 1'b0, key_note(key_id),
              1'b0, mfs_pkg::VEL_ON};
    end else if (fader_move) begin
      tmsg = {mfs_pkg::STAT_CC, strip_ch, 3'h0, fader_id, 1'b0, cc_val};
    end else if (mmc_go) begin
      tmsg = {mfs_pkg::SYSEX_START, mfs_pkg::MMC_ID_RT, mfs_pkg::MMC_ALL};
    end else if (soft_go) begin
      unique case (soft_kind)
        mfs_pkg::MFS_SOFT_NOTE: tmsg = {mfs_pkg::STAT_NOTE_ON, main_ch_q,
                                        1'b0, soft_num, 1'b0, soft_val};
        mfs_pkg::MFS_SOFT_PROG: begin
          tmsg = {mfs_pkg::STAT_PROG, main_ch_q, 1'b0, soft_num, 8'h0};
          tlen = 3'h2;
        end
        default: tmsg = {mfs_pkg::STAT_CC, main_ch_q, 1'b0, soft_num,
                         1'b0, soft_val};
      endcase
    end else begin
      tload = 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      off_pend_q <= 1'b0;
      off_note_q <= 7'h0;
      mmc_step_q <= 2'h0;
      mmc_cmd_q <= 8'h0;
    end else if (idle) begin
      if (off_pend_q) begin
        off_pend_q <= 1'b0;
      end else if (mmc_step_q != 2'h0) begin
        mmc_step_q <= mmc_step_q - 2'h1;
      end else if (key_press) begin
        off_pend_q <= 1'b1;
        off_note_q <= key_note(key_id);
      end else if (!fader_move && mmc_go) begin
        mmc_step_q <= 2'h1;
        mmc_cmd_q <= mmc_cmd;
      end
    end
  end
  mfs_tx u_usb (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(tload),
    .msg(tmsg),
    .len(tlen),
    .busy(usb_busy),
    .byte_data(usb_data),
    .byte_valid(usb_valid),
    .byte_ready(usb_ready)
  );
  mfs_tx u_net (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(tload),
    .msg(tmsg),
    .len(tlen),
    .busy(net_busy),
    .byte_data(net_data),
    .byte_valid(net_valid),
    .byte_ready(net_ready)
  );

  // ****************************************
  // receive path
  // ****************************************
  wire rx_ch_ok = rx_msg.status[3:0] == strip_ch;
  wire rx_on = rx_valid && rx_ch_ok &&
               rx_msg.status[7:4] == mfs_pkg::STAT_NOTE_ON &&
               rx_msg.data2 != 8'h0;
  wire rx_off = rx_valid && rx_ch_ok &&
                (rx_msg.status[7:4] == mfs_pkg::STAT_NOTE_OFF ||
                 (rx_msg.status[7:4] == mfs_pkg::STAT_NOTE_ON &&
                  rx_msg.data2 == 8'h0));
  wire rx_cc = rx_valid && rx_ch_ok &&
               rx_msg.status[7:4] == mfs_pkg::STAT_CC &&
               rx_msg.data1 < 8'(STRIPS);
  wire [6:0] rn = rx_msg.data1[6:0];
  wire note_ok = rn <= mfs_pkg::NOTE_LAST;
  wire [4:0] rs = rn[4:0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mute_q <= '0;
      sel_q <= '0;
      listen_q <= '0;
      last_cc_q <= 7'h0;
      fader_upd <= 1'b0;
      fader_upd_id <= 5'h0;
      fader_upd_pos <= 10'h0;
    end else begin
      if ((rx_on || rx_off) && note_ok) begin
        unique case (rn[6:5])
          2'h0: mute_q[rs] <= rx_on;
          2'h1: sel_q[rs] <= rx_on;
          default: listen_q[rs] <= rx_on;
        endcase
      end
      fader_upd <= rx_cc;
      if (rx_cc) begin
        fader_upd_id <= rx_msg.data1[4:0];
        fader_upd_pos <= rx_pos;
        last_cc_q <= rx_msg.data2[6:0];
      end
    end
  end
  assign mute_state = mute_q;
  assign sel_state = sel_q;
  assign listen_state = listen_q;
endmodule : mfs_strip_mapper

// File: tb/mfs_host_model.sv
`timescale 1ns/1ps
module mfs_host_model (
  input logic ref_clk,
  input logic rst_n,
  input logic slow,
  input logic [7:0] usb_data,
  input logic usb_valid,
  output logic usb_ready,
  input logic [7:0] net_data,
  input logic net_valid,
  output logic net_ready
);
  // ********************
  // byte sinks, stalling when slow
  // ********************
  logic [7:0] usb_q[$];
  logic [7:0] net_q[$];
  logic [2:0] cnt_q;
  assign usb_ready = !slow || cnt_q[0];
  assign net_ready = !slow || (cnt_q[1] && cnt_q[2]);
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      if (usb_valid && usb_ready) usb_q.push_back(usb_data);
      if (net_valid && net_ready) net_q.push_back(net_data);
    end
  end
endmodule : mfs_host_model

// File: tb/mfs_strip_mapper_checker.sv
`timescale 1ns/1ps
module mfs_strip_mapper_checker (
  input logic ref_clk,
  input logic rst_n,
  input logic key_press,
  input logic fader_move,
  input logic cmd_ready,
  input logic [7:0] usb_data,
  input logic usb_valid,
  input logic usb_ready,
  input logic [7:0] net_data,
  input logic net_valid,
  input logic net_ready,
  input logic rx_valid,
  input mfs_pkg::mfs_msg_t rx_msg,
  input logic fader_upd,
  input logic [4:0] fader_upd_id,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata
);
  // ********************
  // port relations
  // ********************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  chk_key_note_on:
    assert property (key_press && cmd_ready |=> usb_valid && net_valid
      && usb_data[7:4] == mfs_pkg::STAT_NOTE_ON)
    else $error("key press gave no note on");
  chk_fader_cc:
    assert property (fader_move && cmd_ready && !key_press |=> usb_valid
      && net_valid && usb_data[7:4] == mfs_pkg::STAT_CC)
    else $error("fader move gave no controller");
  chk_busy_refused:
    assert property (usb_valid || net_valid |-> !cmd_ready)
    else $error("request taken while sending");
  chk_usb_hold:
    assert property (usb_valid && !usb_ready |=> usb_valid
      && $stable(usb_data))
    else $error("usb byte dropped");
  chk_net_hold:
    assert property (net_valid && !net_ready |=> net_valid
      && $stable(net_data))
    else $error("network byte dropped");
  chk_rx_fader:
    assert property (fader_upd |-> $past(rx_valid)
      && $past(rx_msg.status[7:4]) == mfs_pkg::STAT_CC
      && fader_upd_id == $past(rx_msg.data1[4:0]))
    else $error("fader update without controller");
  chk_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : mfs_strip_mapper_checker
bind mfs_strip_mapper mfs_strip_mapper_checker chk_i (.*);

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rst_n, slow;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic key_press, fader_move, mmc_go, soft_go, cmd_ready, rx_valid;
  mfs_pkg::mfs_key_t key_id;
  mfs_pkg::mfs_soft_t soft_kind;
  mfs_pkg::mfs_msg_t rx_msg;
  logic [4:0] fader_id, fader_upd_id;
  logic [9:0] fader_pos, fader_upd_pos;
  logic [7:0] mmc_cmd, usb_data, net_data;
  logic [6:0] soft_num, soft_val;
  logic usb_valid, usb_ready, net_valid, net_ready, fader_upd;
  logic [31:0] mute_state, sel_state, listen_state;
  int err_total = 0;
  int checks = 0;
  mfs_strip_mapper uut (.*);
  mfs_host_model host (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
    .usb_data(usb_data), .usb_valid(usb_valid), .usb_ready(usb_ready),
    .net_data(net_data), .net_valid(net_valid), .net_ready(net_ready));
  // ********************
  // shared tasks
  // ********************
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : rd
  // request held until taken; m is {key, fader, mmc, soft}
  task automatic go(input logic [3:0] m);
    {key_press, fader_move, mmc_go, soft_go} <= m;
    do @(posedge ref_clk); while (!cmd_ready);
    {key_press, fader_move, mmc_go, soft_go} <= 4'h0;
  endtask : go
  // n bytes compared on both links, x more bytes skipped
  task automatic take(input int n, input logic [47:0] e, input int x);
    int t;
    t = 0;
    while ((host.usb_q.size() < n + x || host.net_q.size() < n + x)
           && t < 300) begin
      @(posedge ref_clk);
      t++;
    end
    chk("bytes in time", 32'(t < 300), 32'h1);
    for (int i = 0; i < n + x; i++) begin
      if (i < n) begin
        chk("usb byte", host.usb_q[0], e[8*(n-1-i) +: 8]);
        chk("net byte", host.net_q[0], e[8*(n-1-i) +: 8]);
      end
      void'(host.usb_q.pop_front());
      void'(host.net_q.pop_front());
    end
  endtask : take
  task automatic press(input logic [1:0] k, input logic [4:0] s,
                       input logic [3:0] c);
    key_id <= '{kind: k, strip: s};
    go(4'h8);
    take(3, {24'h0, mfs_pkg::STAT_NOTE_ON, c, 1'b0, k, s, 8'h7f}, 0);
    take(2, {32'h0, mfs_pkg::STAT_NOTE_OFF, c, 1'b0, k, s}, 1);
  endtask : press
  task automatic rx(input logic [23:0] m);
    rx_msg <= m;
    rx_valid <= 1'b1;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    @(posedge ref_clk);
  endtask : rx
  // ********************
  // scenarios
  // ********************
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    rd(mfs_pkg::ADDR_PEND, d, r);
    chk("pend reset", d, 32'h0);
    rd(8'h40, d, r);
    chk("bad read", r, mfs_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1, r);
    chk("bad write", r, mfs_pkg::RESP_SLVERR);
  endtask : t_bus
  task automatic t_keys();
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < 32; s += 31) begin
        press(2'(k), 5'(s), 4'h1);
      end
    end
  endtask : t_keys
  task automatic t_fader();
    fader_id <= 5'h1f;
    fader_pos <= 10'h3ff;
    go(4'h4);
    take(3, {24'h0, mfs_pkg::STAT_CC, 4'h1, 16'h1f7f}, 0);
    fader_id <= 5'h00;
    fader_pos <= 10'h200;
    go(4'h4);
    take(3, {24'h0, mfs_pkg::STAT_CC, 4'h1, 16'h0040}, 0);
  endtask : t_fader
  task automatic t_mmc();
    for (int c = 1; c < 7; c++) begin
      mmc_cmd <= 8'(c);
      go(4'h2);
      take(6, {32'hf07f7f06, 8'(c), 8'hf7}, 0);
    end
  endtask : t_mmc
  task automatic t_soft();
    logic [3:0] st[5] = '{4'h9, 4'hb, 4'hb, 4'hb, 4'hc};
    for (int k = 0; k < 5; k++) begin
      soft_kind <= mfs_pkg::mfs_soft_t'(k);
      go(4'h1);
      if (k == 4) take(2, {32'h0, st[k], 4'h0, 8'h15}, 0);
      else take(3, {24'h0, st[k], 4'h0, 8'h15, 8'h33}, 0);
    end
  endtask : t_soft
  task automatic t_rx();
    rx(24'h91217f);
    chk("sel on", sel_state[1], 1'b1);
    rx(24'h812100);
    chk("sel off", sel_state[1], 1'b0);
    rx(24'h915f7f);
    chk("listen on", listen_state[31], 1'b1);
    rx(24'h91007f);
    chk("mute on", mute_state[0], 1'b1);
    rx(24'h910000);
    chk("mute zero vel", mute_state[0], 1'b0);
    rx(24'h92017f);
    chk("other channel", mute_state[1], 1'b0);
    rx_msg <= 24'hb11f7f;
    rx_valid <= 1'b1;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    @(negedge ref_clk);
    chk("fader pulse", fader_upd, 1'b1);
    @(negedge ref_clk);
    chk("fader pulse end", fader_upd, 1'b0);
    chk("fader id", fader_upd_id, 5'h1f);
    chk("fader pos", fader_upd_pos[9:3], 7'h7f);
    @(posedge ref_clk);
  endtask : t_rx
  task automatic t_chan();
    logic [31:0] d;
    logic [1:0] r;
    wr(mfs_pkg::ADDR_PEND, 32'h1f, r);
    wr(mfs_pkg::ADDR_CTRL, 32'h2, r);
    press(2'h0, 5'h03, 4'h1);
    wr(mfs_pkg::ADDR_PEND, 32'h1f, r);
    wr(mfs_pkg::ADDR_CTRL, 32'h1, r);
    rd(mfs_pkg::ADDR_STAT, d, r);
    chk("law applied", d[5], 1'b1);
    chk("main applied", d[4:1], 4'hf);
    press(2'h1, 5'h03, 4'h0);
    fader_id <= 5'h02;
    fader_pos <= 10'h100;
    go(4'h4);
    take(3, {24'h0, mfs_pkg::STAT_CC, 4'h0, 16'h0210}, 0);
    fader_pos <= 10'h300;
    go(4'h4);
    take(3, {24'h0, mfs_pkg::STAT_CC, 4'h0, 16'h0240}, 0);
    rx(24'hb00530);
    chk("audio pos", fader_upd_pos, 10'h280);
    wr(mfs_pkg::ADDR_PEND, 32'h02, r);
    wr(mfs_pkg::ADDR_CTRL, 32'h1, r);
    press(2'h2, 5'h05, 4'h3);
  endtask : t_chan
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    {rst_n, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, key_press, key_id, fader_move, fader_id} = '0;
    {fader_pos, mmc_go, mmc_cmd, soft_go, rx_valid, rx_msg} = '0;
    s_axi_wstrb = 4'hf;
    soft_kind = mfs_pkg::MFS_SOFT_NOTE;
    soft_num = 7'h15;
    soft_val = 7'h33;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_bus();
    slow <= 1'b1;
    t_keys();
    t_mmc();
    slow <= 1'b0;
    t_fader();
    t_soft();
    t_rx();
    t_chan();
    tally_and_finish();
  end
endmodule : testbench
